// file: rtl/sbcgc_map.vh
`ifndef SBCGC_MAP_VH
`define SBCGC_MAP_VH
`define SBCGC_BIT_STOP 7
`define SBCGC_BIT_SLEEP 6
`define SBCGC_BIT_SWRST_N 5
`define SBCGC_BIT_FLOAT 4
`define SBCGC_BIT_OSC_HI 3
`define SBCGC_BIT_OSC_LO 2
`define SBCGC_CTRL_RESET 8'h20
`define SBCGC_WAIT_0 16'h0010
`define SBCGC_WAIT_1 16'h0040
`define SBCGC_WAIT_2 16'h0100
`define SBCGC_WAIT_3 16'h0400
`endif

// file: rtl/sbcgc_wait_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "sbcgc_map.vh"
module sbcgc_wait_timer (
  input wire clk,
  input wire reset,
  input wire start,
  input wire [1:0] sel,
  output reg done_r
);
  reg [15:0] cnt_r;
  reg run_r;

  function [15:0] sbcgc_len;
    input [1:0] s;
    begin
      case (s)
        2'h0: sbcgc_len = `SBCGC_WAIT_0;
        2'h1: sbcgc_len = `SBCGC_WAIT_1;
        2'h2: sbcgc_len = `SBCGC_WAIT_2;
        default: sbcgc_len = `SBCGC_WAIT_3;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= sbcgc_len(sel);
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 16'h0001) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
endmodule // sbcgc_wait_timer
`default_nettype wire

// file: rtl/sbcgc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "sbcgc_map.vh"
module sbcgc_ctrl (
  input wire clk,
  input wire reset,
  input wire ctrl_we,
  input wire [7:0] ctrl_wdata,
  input wire bus_released,
  input wire [7:0] wake_irq,
  input wire [7:0] irq_enable,
  input wire [7:0] stop_capable,
  input wire irq_level_ok,
  input wire dma_req,
  input wire ext_reset_pin_n,
  input wire watchdog_reset,
  input wire power_on_reset,
  output reg [7:0] standby_control_register,
  output reg cpu_clk_en_r,
  output reg bus_clk_en_r,
  output reg dma_clk_en_r,
  output reg per_clk_en_r,
  output reg osc_en_r,
  output reg pin_hold_r,
  output reg pin_float_r,
  output reg internal_reset_r,
  output reg take_vector_r,
  output reg continue_r,
  output reg watchdog_clear_r,
  output reg in_stop_r,
  output reg in_sleep_r
);
  // ****************
  // states
  // ****************
  localparam [10:0] S_RUN = 11'h001;
  localparam [10:0] S_STOP_WAITBUS = 11'h002;
  localparam [10:0] S_STOP_GATE = 11'h004;
  localparam [10:0] S_STOP = 11'h008;
  localparam [10:0] S_OSC_WAIT = 11'h010;
  localparam [10:0] S_RESTORE = 11'h020;
  localparam [10:0] S_SLP_WAITBUS = 11'h040;
  localparam [10:0] S_SLP_GATE = 11'h080;
  localparam [10:0] S_SLEEP = 11'h100;
  localparam [10:0] S_SLP_RESTORE = 11'h200;
  localparam [10:0] S_RESET = 11'h400;

  reg [10:0] state_r;
  reg [2:0] step_r;
  reg from_reset_r;
  reg timer_start_r;
  wire timer_done;

  // ****************
  // wake and reset decode
  // ****************
  wire [7:0] en_irq = wake_irq & irq_enable;
  wire any_irq = |en_irq;
  wire stop_wake = |(en_irq & stop_capable);
  wire sw_reset = ctrl_we & ~ctrl_wdata[`SBCGC_BIT_SWRST_N];
  wire rst_src = ~ext_reset_pin_n | sw_reset | watchdog_reset | power_on_reset;
  wire wr_stop = ctrl_we & ctrl_wdata[`SBCGC_BIT_STOP];
  wire wr_sleep = ctrl_we & ~ctrl_wdata[`SBCGC_BIT_STOP]
    & ctrl_wdata[`SBCGC_BIT_SLEEP];

  sbcgc_wait_timer u_wait (
    .clk(clk),
    .reset(reset),
    .start(timer_start_r),
    .sel(standby_control_register[`SBCGC_BIT_OSC_HI:`SBCGC_BIT_OSC_LO]),
    .done_r(timer_done)
  );

  // ****************
  // control register
  // ****************
  always @(posedge clk) begin
    if (reset) begin
      standby_control_register <= `SBCGC_CTRL_RESET;
    end else if (ctrl_we) begin
      standby_control_register <= ctrl_wdata;
      if (any_irq) begin
        standby_control_register[`SBCGC_BIT_STOP] <= 1'b0;
        standby_control_register[`SBCGC_BIT_SLEEP] <= 1'b0;
      end
      standby_control_register[`SBCGC_BIT_SWRST_N] <= 1'b1;
    end else if ((state_r == S_RESTORE || state_r == S_SLP_RESTORE) && step_r == 3'h0) begin
      standby_control_register[`SBCGC_BIT_STOP] <= 1'b0;
      standby_control_register[`SBCGC_BIT_SLEEP] <= 1'b0;
    end
  end

  // ****************
  // sequencer
  // ****************
  always @(posedge clk) begin
    if (reset) begin
      state_r <= S_RESET;
      step_r <= 3'h0;
      from_reset_r <= 1'b1;
      timer_start_r <= 1'b0;
      cpu_clk_en_r <= 1'b1;
      bus_clk_en_r <= 1'b1;
      dma_clk_en_r <= 1'b1;
      per_clk_en_r <= 1'b1;
      osc_en_r <= 1'b1;
      pin_hold_r <= 1'b0;
      pin_float_r <= 1'b0;
      internal_reset_r <= 1'b1;
      take_vector_r <= 1'b0;
      continue_r <= 1'b0;
      watchdog_clear_r <= 1'b0;
      in_stop_r <= 1'b0;
      in_sleep_r <= 1'b0;
    end else begin
      timer_start_r <= 1'b0;
      take_vector_r <= 1'b0;
      continue_r <= 1'b0;
      // a reset during a wake's settle wait restarts it as a reset wait
      if (rst_src && state_r != S_RESET && !(state_r == S_OSC_WAIT && from_reset_r)) begin
        state_r <= S_OSC_WAIT;
        from_reset_r <= 1'b1;
        internal_reset_r <= 1'b1;
        osc_en_r <= 1'b1;
        timer_start_r <= 1'b1;
        // power-on keeps every clock running through the wait
        {cpu_clk_en_r, bus_clk_en_r, dma_clk_en_r, per_clk_en_r} <= {4{power_on_reset}};
        in_stop_r <= 1'b0;
        in_sleep_r <= 1'b0;
        pin_hold_r <= 1'b0;
        pin_float_r <= 1'b0;
        watchdog_clear_r <= 1'b0;
      end else begin
        case (state_r)
          S_RESET: begin
            // power-on: all clocks run through the wait
            timer_start_r <= 1'b1;
            state_r <= S_OSC_WAIT;
          end
          S_RUN: begin
            internal_reset_r <= 1'b0;
            if (wr_stop && !any_irq) begin
              state_r <= S_STOP_WAITBUS;
            end else if (wr_sleep && !any_irq && !dma_req) begin
              state_r <= S_SLP_WAITBUS;
            end else if (standby_control_register[`SBCGC_BIT_SLEEP] && !any_irq
                && !dma_req && !standby_control_register[`SBCGC_BIT_STOP]) begin
              state_r <= S_SLP_WAITBUS;
            end
          end
          S_STOP_WAITBUS: begin
            if (bus_released) begin
              state_r <= S_STOP_GATE;
              step_r <= 3'h0;
            end
          end
          S_STOP_GATE: begin
            step_r <= step_r + 3'h1;
            case (step_r)
              3'h0: cpu_clk_en_r <= 1'b0;
              3'h1: bus_clk_en_r <= 1'b0;
              3'h2: dma_clk_en_r <= 1'b0;
              3'h3: per_clk_en_r <= 1'b0;
              default: begin
                osc_en_r <= 1'b0;
                state_r <= S_STOP;
                in_stop_r <= 1'b1;
                watchdog_clear_r <= 1'b1;
                pin_hold_r <= ~standby_control_register[`SBCGC_BIT_FLOAT];
                pin_float_r <= standby_control_register[`SBCGC_BIT_FLOAT];
              end
            endcase
          end
          S_STOP: begin
            if (stop_wake) begin
              osc_en_r <= 1'b1;
              timer_start_r <= 1'b1;
              from_reset_r <= 1'b0;
              in_stop_r <= 1'b0;
              state_r <= S_OSC_WAIT;
            end
          end
          S_OSC_WAIT: begin
            if (timer_done) begin
              state_r <= S_RESTORE;
              step_r <= 3'h0;
              in_stop_r <= 1'b0;
              pin_hold_r <= 1'b0;
              pin_float_r <= 1'b0;
              watchdog_clear_r <= 1'b0;
            end
          end
          S_RESTORE: begin
            step_r <= step_r + 3'h1;
            case (step_r)
              3'h0: per_clk_en_r <= 1'b1;
              3'h1: dma_clk_en_r <= 1'b1;
              3'h2: bus_clk_en_r <= 1'b1;
              default: begin
                cpu_clk_en_r <= 1'b1;
                state_r <= S_RUN;
                step_r <= 3'h0;
                internal_reset_r <= 1'b0;
                if (!from_reset_r) begin
                  take_vector_r <= irq_level_ok;
                  continue_r <= ~irq_level_ok;
                end
                from_reset_r <= 1'b0;
              end
            endcase
          end
          S_SLP_WAITBUS: begin
            if (bus_released) begin
              state_r <= S_SLP_GATE;
              step_r <= 3'h0;
            end
          end
          S_SLP_GATE: begin
            step_r <= step_r + 3'h1;
            if (step_r == 3'h0) begin
              cpu_clk_en_r <= 1'b0;
            end else begin
              bus_clk_en_r <= 1'b0;
              state_r <= S_SLEEP;
              in_sleep_r <= 1'b1;
              watchdog_clear_r <= 1'b1;
            end
          end
          S_SLEEP: begin
            if (any_irq) begin
              state_r <= S_SLP_RESTORE;
              step_r <= 3'h0;
              in_sleep_r <= 1'b0;
              watchdog_clear_r <= 1'b0;
            end
          end
          S_SLP_RESTORE: begin
            step_r <= step_r + 3'h1;
            if (step_r == 3'h0) begin
              bus_clk_en_r <= 1'b1;
            end else begin
              cpu_clk_en_r <= 1'b1;
              state_r <= S_RUN;
              step_r <= 3'h0;
              take_vector_r <= irq_level_ok;
              continue_r <= ~irq_level_ok;
            end
          end
          default: state_r <= S_RUN;
        endcase
      end
    end
  end

endmodule // sbcgc_ctrl
`default_nettype wire

// file: verification/sbcgc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// clock gating, watchdog clear and pin float checks
// ****
module sbcgc_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] standby_control_register,
  input wire logic cpu_clk_en_r,
  input wire logic bus_clk_en_r,
  input wire logic dma_clk_en_r,
  input wire logic per_clk_en_r,
  input wire logic osc_en_r,
  input wire logic pin_float_r,
  input wire logic watchdog_clear_r,
  input wire logic in_stop_r,
  input wire logic in_sleep_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_osc_settle;
    !per_clk_en_r [*8];
  endsequence
  sequence s_cpu_last;
    !cpu_clk_en_r ##1 cpu_clk_en_r;
  endsequence
  chk_stop_order: assert property (
    $fell(per_clk_en_r) |-> !(cpu_clk_en_r | bus_clk_en_r | dma_clk_en_r))
    else $error("gate order");
  chk_stop_dark: assert property (
    in_stop_r |-> !(osc_en_r | per_clk_en_r | cpu_clk_en_r)) else $error("stop clocks");
  chk_sleep_mix: assert property (
    in_sleep_r |-> osc_en_r && dma_clk_en_r && per_clk_en_r && !bus_clk_en_r)
    else $error("sleep clocks");
  chk_wake_full: assert property (
    $rose(cpu_clk_en_r) |-> bus_clk_en_r && dma_clk_en_r && per_clk_en_r && osc_en_r)
    else $error("cpu early");
  chk_osc_settle: assert property (
    $rose(osc_en_r) |-> s_osc_settle) else $error("no settle wait");
  chk_bus_then_cpu: assert property (
    $rose(bus_clk_en_r) |-> s_cpu_last) else $error("cpu restore");
  chk_wdog_clear: assert property (
    (in_stop_r | in_sleep_r) |-> watchdog_clear_r) else $error("watchdog clear");
  chk_pin_float: assert property (
    in_stop_r |-> pin_float_r == standby_control_register[4]) else $error("pin float");
endmodule // sbcgc_properties
bind sbcgc_ctrl sbcgc_properties u_props (.clk, .reset, .standby_control_register,
  .cpu_clk_en_r, .bus_clk_en_r, .dma_clk_en_r, .per_clk_en_r, .osc_en_r, .pin_float_r,
  .watchdog_clear_r, .in_stop_r, .in_sleep_r);
`default_nettype wire

// file: verification/sbcgc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// cpu core and interrupt sources
// ****
module sbcgc_cpu_model #(parameter int REL_DLY = 6) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] standby_control_register,
  input wire logic cpu_clk_en_r,
  input wire logic served,
  input wire logic [7:0] irq_set,
  output logic bus_released,
  output logic [7:0] wake_irq
);
  int cnt = 0;
  always @(posedge clk) begin
    // bus held through the trailing no-ops
    if (reset || (cpu_clk_en_r && standby_control_register[7:6] == 2'b00)) cnt <= 0;
    else if (cnt < REL_DLY) cnt <= cnt + 1;
    if (reset || served) wake_irq <= 8'h00;
    else wake_irq <= wake_irq | irq_set;
  end
  assign bus_released = (cnt >= REL_DLY);
endmodule // sbcgc_cpu_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbcgc_map.vh"
module tb_top;
  logic clk = 1'b0, reset = 1'b1, ctrl_we = 1'b0, irq_level_ok = 1'b0, dma_req = 1'b0;
  logic ext_reset_pin_n = 1'b1, watchdog_reset = 1'b0, power_on_reset = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, irq_enable = 8'h05, stop_capable = 8'h01, irq_set = 8'h00;
  logic [7:0] wake_irq, standby_control_register;
  logic bus_released, cpu_clk_en_r, bus_clk_en_r, dma_clk_en_r, per_clk_en_r, osc_en_r;
  logic pin_hold_r, pin_float_r, internal_reset_r, take_vector_r, continue_r;
  logic watchdog_clear_r, in_stop_r, in_sleep_r;
  int fail_count = 0, n_tests = 0, wcnt = 0, tvc = 0, ctc = 0, w0 = 0, t0 = 0, c0 = 0, i;
  localparam int WT [4] = '{`SBCGC_WAIT_0, `SBCGC_WAIT_1, `SBCGC_WAIT_2, `SBCGC_WAIT_3};
  always #25 clk = ~clk;
  sbcgc_ctrl DUT (.clk, .reset, .ctrl_we, .ctrl_wdata, .bus_released, .wake_irq, .irq_enable,
    .stop_capable, .irq_level_ok, .dma_req, .ext_reset_pin_n, .watchdog_reset, .power_on_reset,
    .standby_control_register, .cpu_clk_en_r, .bus_clk_en_r, .dma_clk_en_r, .per_clk_en_r,
    .osc_en_r, .pin_hold_r, .pin_float_r, .internal_reset_r, .take_vector_r, .continue_r,
    .watchdog_clear_r, .in_stop_r, .in_sleep_r);
  sbcgc_cpu_model u_cpu (.clk, .reset, .standby_control_register, .cpu_clk_en_r,
    .served(take_vector_r | continue_r | internal_reset_r), .irq_set, .bus_released, .wake_irq);
  always @(posedge clk) begin
    if (osc_en_r && !per_clk_en_r) wcnt <= wcnt + 1;
    if (take_vector_r) tvc <= tvc + 1;
    if (continue_r) ctc <= ctc + 1;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] d);
    @(negedge clk);
    // requests come from rom code with matched gears on the divided oscillator
    ctrl_we = 1'b1;
    ctrl_wdata = d;
    @(negedge clk);
    ctrl_we = 1'b0;
  endtask
  task fire(input logic [7:0] b);
    @(negedge clk);
    irq_set = b;
    @(negedge clk);
    irq_set = 8'h00;
  endtask
  task wt(input bit run);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk);
      if (run && cpu_clk_en_r === 1'b1 && internal_reset_r === 1'b0) break;
      if (!run && (in_stop_r === 1'b1 || in_sleep_r === 1'b1)) break;
    end
    repeat (3) @(negedge clk);
  endtask
  task print_verdict;
    $display("mismatches %0d, checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
  // ****
  // stop entry and interrupt wake per wait select
  // ****
  initial begin
    repeat (5) @(negedge clk);
    chk(standby_control_register, `SBCGC_CTRL_RESET);
    chk(8'({cpu_clk_en_r, bus_clk_en_r, dma_clk_en_r, per_clk_en_r, osc_en_r}), 8'h1F);
    reset = 1'b0;
    wt(1);
    for (i = 0; i < 4; i++) begin
      irq_level_ok = i[1];
      wr({3'b101, i[0], i[1:0], 2'b00});
      wt(0);
      chk(8'({in_stop_r, osc_en_r, pin_hold_r, pin_float_r}), 8'({2'b10, !i[0], i[0]}));
      fire(8'h06);
      repeat (30) @(negedge clk);
      chk(8'(in_stop_r), 8'h01);
      w0 = wcnt;
      t0 = tvc;
      c0 = ctc;
      fire(8'h01);
      wt(1);
      chk(8'(wcnt - w0 >= WT[i] && wcnt - w0 <= WT[i] + 4), 8'h01);
      chk(8'({2'(tvc - t0), 2'(ctc - c0)}), i[1] ? 8'h04 : 8'h01);
      chk(8'(standby_control_register[7:6]), 8'h00);
    end
    // ****
    // refused requests, then reset sources
    // ****
    fire(8'h01);
    wr(8'hA0);
    repeat (20) @(negedge clk);
    chk(8'({in_stop_r, cpu_clk_en_r, standby_control_register[7]}), 8'h02);
    wr(8'h60);
    repeat (20) @(negedge clk);
    chk(8'({in_sleep_r, cpu_clk_en_r, standby_control_register[6]}), 8'h02);
    for (i = 0; i < 4; i++) begin
      if (i == 1) wr(8'hA0);
      if (i == 2) wr(8'h60);
      if (i == 1 || i == 2) wt(0);
      if (i == 0) wr(8'h00);
      @(negedge clk);
      ext_reset_pin_n = (i != 1);
      watchdog_reset = (i == 2);
      power_on_reset = (i == 3);
      repeat (4) @(negedge clk);
      chk(8'({per_clk_en_r, osc_en_r}), 8'({i == 3, 1'b1}));
      chk(8'(internal_reset_r), 8'h01);
      ext_reset_pin_n = 1'b1;
      watchdog_reset = 1'b0;
      power_on_reset = 1'b0;
      wt(1);
      chk(8'({internal_reset_r, standby_control_register[7:6]}), 8'h00);
    end
    // ****
    // sleep deferred by dma, woken without settle wait
    // ****
    dma_req = 1'b1;
    wr(8'h60);
    repeat (20) @(negedge clk);
    chk(8'(in_sleep_r), 8'h00);
    dma_req = 1'b0;
    wt(0);
    chk(8'({in_sleep_r, osc_en_r, dma_clk_en_r, per_clk_en_r, cpu_clk_en_r}), 8'h1E);
    w0 = wcnt;
    fire(8'h04);
    wt(1);
    chk(8'({cpu_clk_en_r, 4'(wcnt - w0)}), 8'h10);
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
